// >>> core/rbp_pkg.sv
// Package for the RAM block power and retention register bank
package rbp_pkg;
   localparam logic [11:0] RBP_CTRL_OFF = 12'h960;
   localparam logic [11:0] RBP_SET_OFF = 12'h964;
   localparam logic [11:0] RBP_CLR_OFF = 12'h968;
   localparam logic [31:0] RBP_CTRL_RST = 32'h0000ffff;
   localparam int RBP_SECTIONS = 16;
   localparam int RBP_ON_LSB = 0;
   localparam int RBP_KEEP_LSB = 16;
   localparam logic [1:0] RBP_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] RBP_HTRANS_SEQ = 2'h3;

   // Section power state: on bits low half, keep bits high half
   typedef struct packed {
      logic [15:0] keep;
      logic [15:0] on;
   } rbp_ctrl_t;

   // Captured address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [11:0] addr;
   } rbp_aphase_t;

   // Module state apart from the sleep synchroniser
   typedef struct packed {
      rbp_ctrl_t ctrl;
      rbp_aphase_t ap;
      logic [31:0] rdata;
      logic [15:0] pwr;
   } rbp_state_t;
endpackage

// >>> core/rbp_regs.sv
// RAM block power and retention registers with an AHB-Lite slave port
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps

module rbp_regs (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic system_off,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic [15:0] section_power_on,
   output logic [15:0] section_keep_contents
);

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   rbp_pkg::rbp_state_t s_q;
   rbp_pkg::rbp_state_t s_d;
   logic off_meta_q;
   logic off_sync_q;

   // Register index decode used for both reads and writes
   function automatic logic [1:0] reg_sel(input logic [11:0] a);
      if (a == rbp_pkg::RBP_CTRL_OFF) begin
         return 2'h1;
      end else if (a == rbp_pkg::RBP_SET_OFF) begin
         return 2'h2;
      end else if (a == rbp_pkg::RBP_CLR_OFF) begin
         return 2'h3;
      end
      return 2'h0;
   endfunction

   // Sleep request arrives from the power manager domain: two stages
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         off_meta_q <= 1'b0;
         off_sync_q <= 1'b0;
      end else begin
         off_meta_q <= system_off;
         off_sync_q <= off_meta_q;
      end
   end

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   // Zero wait states: write data lands one edge after the data phase
   always_comb begin
      logic [1:0] sel;
      sel = 2'h0;
      s_d = s_q;
      s_d.ap.valid = 1'b0;
      // Data phase of a captured write updates the selected register
      if (s_q.ap.valid && s_q.ap.write) begin
         sel = reg_sel(s_q.ap.addr);
         unique case (sel)
            2'h1: s_d.ctrl = hwdata;
            2'h2: s_d.ctrl = s_q.ctrl | hwdata;
            2'h3: s_d.ctrl.on = s_q.ctrl.on & ~hwdata[15:0];
            default: s_d.ctrl = s_q.ctrl;
         endcase
      end
      // Address phase capture, only when the bus is ready
      if (hsel && hready && (htrans == rbp_pkg::RBP_HTRANS_NONSEQ ||
            htrans == rbp_pkg::RBP_HTRANS_SEQ)) begin
         s_d.ap.valid = 1'b1;
         s_d.ap.write = hwrite;
         s_d.ap.addr = {haddr[11:2], 2'h0};
         // Reads return the settled state; unmapped reads give zero
         if (!hwrite && reg_sel({haddr[11:2], 2'h0}) != 2'h0) begin
            s_d.rdata = s_d.ctrl;
         end else begin
            s_d.rdata = 32'h0;
         end
      end
      // Sleep forces all sections off without touching the settings
      s_d.pwr = off_sync_q ? 16'h0 : s_d.ctrl.on;
   end

   // Registered state; reset values give all sections on
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q.ctrl <= rbp_pkg::RBP_CTRL_RST;
         s_q.ap <= '0;
         s_q.rdata <= 32'h0;
         s_q.pwr <= rbp_pkg::RBP_CTRL_RST[15:0];
      end else begin
         s_q <= s_d;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   // The slave never stalls and always answers OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign section_power_on = s_q.pwr;
   assign section_keep_contents = s_q.ctrl.keep;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   set_on_bits_a: assert property (
      s_q.ap.valid && s_q.ap.write && s_q.ap.addr == 12'h964
      |=> ((s_q.ctrl.on & $past(hwdata[15:0])) == $past(hwdata[15:0])))
      else $error("set write failed to turn sections on");
   set_keep_bits_a: assert property (
      s_q.ap.valid && s_q.ap.write && s_q.ap.addr == 12'h964
      |=> ((s_q.ctrl.keep & $past(hwdata[31:16])) == $past(hwdata[31:16])))
      else $error("set write failed to enable retention");
   clear_on_bits_a: assert property (
      s_q.ap.valid && s_q.ap.write && s_q.ap.addr == 12'h968
      |=> ((s_q.ctrl.on & $past(hwdata[15:0])) == 16'h0))
      else $error("clear write failed to turn sections off");
   clear_keeps_keep_a: assert property (
      s_q.ap.valid && s_q.ap.write && s_q.ap.addr == 12'h968
      |=> $stable(s_q.ctrl.keep))
      else $error("clear write disturbed retention bits");
   set_no_clear_a: assert property (
      s_q.ap.valid && s_q.ap.write && s_q.ap.addr == 12'h964
      |=> ((s_q.ctrl & $past(s_q.ctrl)) == $past(s_q.ctrl)))
      else $error("set write cleared a bit");
   ctrl_write_a: assert property (
      s_q.ap.valid && s_q.ap.write && s_q.ap.addr == 12'h960
      |=> s_q.ctrl == $past(hwdata))
      else $error("control write not stored");
   sleep_off_a: assert property (
      off_sync_q [*2] |-> section_power_on == 16'h0)
      else $error("section powered during deep sleep");
   awake_follow_a: assert property (
      !off_sync_q ##1 !off_sync_q |-> section_power_on == $past(s_d.ctrl.on))
      else $error("power output does not follow on bits");
   read_back_a: assert property (
      hsel && hready && htrans == 2'h2 && !hwrite && haddr[11:0] == 12'h960
      && !(s_q.ap.valid && s_q.ap.write)
      |=> hrdata == $past(s_q.ctrl))
      else $error("control read mismatch");

   // -------------------------------------------------------------
   // Check helpers
   // -------------------------------------------------------------
   // Strobes built from the bus and the captured address phase s_q.ap, so the checks below compare
   // against bus values rather than mirroring the update logic
   logic chk_take;
   logic chk_rd_ctrl;
   logic wr_any;
   logic wr_ctrl;
   logic wr_set;
   logic wr_clr;
   logic wr_other;

   // An address phase is taken whenever a real transfer meets hready
   assign chk_take = hsel && hready && htrans[1];
   // Read of the control word being taken this cycle
   assign chk_rd_ctrl = chk_take && !hwrite
      && haddr[11:2] == rbp_pkg::RBP_CTRL_OFF[11:2];
   // Data-phase write strobes, one per register
   assign wr_any = s_q.ap.valid && s_q.ap.write;
   assign wr_ctrl = wr_any && s_q.ap.addr == rbp_pkg::RBP_CTRL_OFF;
   assign wr_set = wr_any && s_q.ap.addr == rbp_pkg::RBP_SET_OFF;
   assign wr_clr = wr_any && s_q.ap.addr == rbp_pkg::RBP_CLR_OFF;
   // Writes to unmapped words must be dropped
   assign wr_other = wr_any && !wr_ctrl && !wr_set && !wr_clr;

   // -------------------------------------------------------------
   // Further checks
   // -------------------------------------------------------------
   // Zero bits of a set write must leave both halves untouched
   set_zero_hold_a: assert property (
      wr_set |=> ((s_q.ctrl & ~$past(hwdata))
      == ($past(s_q.ctrl) & ~$past(hwdata))))
      else $error("set write changed a bit written as zero");

   // Zero bits of a clear write must leave the on bits untouched
   clr_zero_hold_a: assert property (
      wr_clr |=> ((s_q.ctrl.on & ~$past(hwdata[15:0]))
      == ($past(s_q.ctrl.on) & ~$past(hwdata[15:0]))))
      else $error("clear write changed a bit written as zero");

   // Without a write the settings must never drift
   idle_hold_a: assert property (
      !wr_any |=> $stable(s_q.ctrl))
      else $error("control changed without a write");

   // A stray write to a neighbouring word must not alter the control word
   unmapped_drop_a: assert property (
      wr_other |=> $stable(s_q.ctrl))
      else $error("unmapped write changed the control word");

   // Reads of unmapped words return zero rather than stale data
   unmapped_read_a: assert property (
      chk_take && !hwrite && reg_sel({haddr[11:2], 2'h0}) == 2'h0
      |=> hrdata == 32'h0)
      else $error("unmapped read returned data");

   // Back to back: a read right after a control write sees new data
   rd_after_ctrl_a: assert property (
      chk_rd_ctrl && wr_ctrl |=> hrdata == $past(hwdata))
      else $error("read after control write is stale");

   // Back to back: a read right after a set write sees the OR
   rd_after_set_a: assert property (
      chk_rd_ctrl && wr_set
      |=> hrdata == ($past(s_q.ctrl) | $past(hwdata)))
      else $error("read after set write is stale");

   // Back to back: a read right after a clear write sees the result
   rd_after_clr_a: assert property (
      chk_rd_ctrl && wr_clr
      |=> hrdata == {$past(s_q.ctrl.keep),
         $past(s_q.ctrl.on) & ~$past(hwdata[15:0])})
      else $error("read after clear write is stale");

   // Read data stands until the next address phase is taken
   rdata_stand_a: assert property (
      !chk_take |=> $stable(hrdata))
      else $error("read data moved without a transfer");

   // A section can only be powered if its on bit is set
   on_subset_a: assert property (
      (section_power_on & ~s_q.ctrl.on) == 16'h0)
      else $error("section powered with its on bit clear");

   // Awake and idle, the power outputs track the on bits
   power_follow_a: assert property (
      !off_sync_q && !wr_any
      |=> section_power_on == $past(s_q.ctrl.on))
      else $error("power output lags the on bits");

   // Entering sleep drops power one edge after the synced request
   sleep_entry_a: assert property (
      $rose(off_sync_q) |=> section_power_on == 16'h0)
      else $error("power not dropped on sleep entry");

   // Sleep must not disturb the retention settings
   sleep_keep_a: assert property (
      off_sync_q && !wr_any |=> $stable(section_keep_contents))
      else $error("sleep disturbed retention outputs");

   // The second stage reads only the first: no skipped stage
   sync_chain_a: assert property (
      off_sync_q == $past(off_meta_q))
      else $error("sleep synchroniser skipped a stage");

   // A control write reaches the retention outputs at once
   keep_output_a: assert property (
      wr_ctrl |=> section_keep_contents == $past(hwdata[31:16]))
      else $error("retention outputs miss a control write");

   // A control write reaches the power outputs while awake
   on_output_a: assert property (
      wr_ctrl && !off_sync_q
      |=> section_power_on == $past(hwdata[15:0]))
      else $error("power outputs miss a control write");

   // A set write powers the named sections while awake
   set_power_out_a: assert property (
      wr_set && !off_sync_q
      |=> ((section_power_on & $past(hwdata[15:0]))
      == $past(hwdata[15:0])))
      else $error("set write did not power sections");

   // A clear write removes power from the named sections
   clr_power_out_a: assert property (
      wr_clr |=> ((section_power_on & $past(hwdata[15:0])) == 16'h0))
      else $error("clear write left sections powered");

   // Main scenarios worth seeing at least once
   read_cov_c: cover property (chk_rd_ctrl && wr_set);
   wake_cov_c: cover property ($fell(off_sync_q));
   set_cov_c: cover property (s_q.ap.valid && s_q.ap.write
      && s_q.ap.addr == 12'h964);
   clr_cov_c: cover property (s_q.ap.valid && s_q.ap.write
      && s_q.ap.addr == 12'h968);
   sleep_cov_c: cover property (off_sync_q && s_q.ctrl.keep != 16'h0);

endmodule // rbp_regs

// >>> sim/rbp_regs_bench.sv
// Self-checking bench for the RAM block power and retention registers
`timescale 1ns/10ps
module rbp_regs_bench;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sys_off = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, exp_q, d;
   logic [31:0] rng = 32'h2b;
   logic [1:0] htrans = '0, op;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp;
   logic [15:0] pw, kc;
   logic [1:0] cop [3] = '{2'h1, 2'h2, 2'h1};
   logic [31:0] cdat [3] = '{32'h0, 32'hffffffff, 32'hffff0000};
   int n_mismatch = 0, samples_checked = 0;
   always #5 hclk = ~hclk;
   rbp_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .system_off(sys_off),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .section_power_on(pw), .section_keep_contents(kc));
   // ------------------------------------------------------------
   // Helpers: random source, expected state, bus cycles
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // Clear only touches the on bits, so keep bits survive it
   function automatic logic [31:0] nxt(input logic [1:0] o,
      input logic [31:0] c, input logic [31:0] v);
      case (o)
         2'h0: return v;
         2'h1: return c | v;
         default: return c & ~{16'h0, v[15:0]};
      endcase
   endfunction
   task automatic complete_run();
      $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bounded wait for hready at a rising edge
   task automatic wait_rdy();
      int i;
      i = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && i < 20) begin
         @(posedge hclk);
         i++;
      end
      if (i == 20) begin
         n_mismatch++;
         complete_run();
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] v);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= v;
      wait_rdy();
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   // Main sequence: reset, corners, random mix, sleep
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("power_on", 32'hffff, {16'h0, pw});
      chk("keep", 32'h0, {16'h0, kc});
      exp_q = 32'h0000ffff;
      xfer(1'b0, 12'h960, 32'h0);
      chk("ctrl", exp_q, rd);
      for (int i = 0; i < 40; i++) begin
         rng = xs(rng);
         op = (i < 3) ? cop[i] : 2'(rng % 3);
         rng = xs(rng);
         d = (i < 3) ? cdat[i] : rng;
         xfer(1'b1, 12'h960 + 12'(op) * 12'h4, d);
         exp_q = nxt(op, exp_q, d);
         xfer(1'b0, 12'h960, 32'h0);
         chk("ctrl", exp_q, rd);
         chk("outs", exp_q, {kc, pw});
      end
      xfer(1'b1, 12'h96c, 32'h0);
      xfer(1'b0, 12'h96c, 32'h0);
      chk("unmapped", 32'h0, rd);
      sys_off <= 1'b1;
      repeat (4) @(posedge hclk);
      chk("sleep", {exp_q[31:16], 16'h0}, {kc, pw});
      sys_off <= 1'b0;
      repeat (4) @(posedge hclk);
      chk("wake", exp_q, {kc, pw});
      complete_run();
   end
endmodule // rbp_regs_bench
